// File: pkg/tsp_pkg.sv
// shared constants for the serial temperature sensor link
package tsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned CONV_TIME_MS    = 300;
  localparam int unsigned CONV_CYCLES_DEF =
    CONV_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          CONV_CNT_W      = 23;
  localparam int unsigned SCK_HALF_NS     = 500;
  localparam int unsigned SCK_HALF_CYC    = SCK_HALF_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  HALF_LAST       = 4'(SCK_HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // sensor registers
  localparam int          WORD_W     = 16;
  localparam int          TEMP_W     = 13;
  // value arbitrary
  localparam logic [7:0]  IDENT_CODE = 8'h3c;
  localparam logic [5:0]  IDENT_FILL = 6'h00;
  localparam logic [1:0]  UNDEF_BITS = 2'h0;
  localparam logic [12:0] TEMP_RESET = 13'h1fe0;
  localparam logic [7:0]  MODE_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // link framing
  localparam logic [3:0]  READ_LAST  = 4'hf;
  localparam logic [3:0]  DRIVE_LAST = 4'hd;
  localparam logic [3:0]  WRITE_LAST = 4'hf;
  localparam logic [3:0]  WRITE_MIN  = 4'h8;
  localparam logic [4:0]  PHASE_BITS = 5'h10;
  localparam int          PIN_CS     = 0;
  localparam int          PIN_SCK    = 1;
  localparam int          PIN_SIO    = 2;
  localparam logic [2:0]  PIN_IDLE   = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // host controller registers
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_TXDATA  = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_RXDATA  = 8'h0c;
  localparam int          CTRL_START  = 0;
  localparam int          CTRL_WRITE  = 1;
  localparam int          CTRL_HOLD   = 2;
  localparam int          CTRL_RDLEN  = 4;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_SEL    = 1;
  localparam int          STAT_BAD    = 2;

endpackage

// File: pkg/tsp_link_if.sv
// three-wire link between the sensor and its host controller
`timescale 1ns/100ps
interface tsp_link_if;
  logic csN;
  logic sck;
  logic hostSioOut;
  logic hostSioOe;
  logic devSioOut;
  logic devSioOe;
  logic sio;

  // resolved data line, pulled high when nobody drives
  assign sio = hostSioOe ? hostSioOut : (devSioOe ? devSioOut : 1'b1);

  modport dev (
    input  csN,
    input  sck,
    input  sio,
    output devSioOut,
    output devSioOe
  );

  modport host (
    output csN,
    output sck,
    output hostSioOut,
    output hostSioOe,
    input  sio
  );
endinterface

// File: rtl/tsp_sensor.sv
// sensor end of the three-wire link: result, mode and ident registers
`timescale 1ns/100ps
module tsp_sensor
  import tsp_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYCLES_DEF
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  tsp_link_if.dev                link,
  input  wire logic [TEMP_W-1:0] tempIn,
  output logic                   shutdown,
  output logic      [7:0]        modeCode,
  output logic                   firstDone,
  output logic                   convPulse
);

  typedef enum logic [3:0] {
    PH_IDLE  = 4'b0001,
    PH_READ  = 4'b0010,
    PH_WRITE = 4'b0100,
    PH_ARM   = 4'b1000
  } tsp_phase_t;

  tsp_phase_t              phase;
  logic [2:0]              pinRaw;
  logic [2:0]              syncA;
  logic [2:0]              syncB;
  logic [2:0]              syncC;
  logic [2:0]              filt;
  logic [2:0]              agree;
  logic                    selected;
  logic                    csFall;
  logic                    csRise;
  logic                    sckRise;
  logic                    sckFall;
  logic                    sioBit;
  logic [CONV_CNT_W-1:0]   convCnt;
  logic [TEMP_W-1:0]       result;
  logic [WORD_W-1:0]       wordOut;
  logic [WORD_W-1:0]       outSr;
  logic [WORD_W-1:0]       inSr;
  logic [3:0]              cnt;
  logic                    sioOe;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, change taken once second and third stage agree
  assign pinRaw = {link.sio, link.sck, link.csN};
  assign agree  = ~(syncB ^ syncC);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= PIN_IDLE;
      syncB <= PIN_IDLE;
      syncC <= PIN_IDLE;
      filt  <= PIN_IDLE;
    end else if (clkEn) begin
      syncA <= pinRaw;
      syncB <= syncA;
      syncC <= syncB;
      filt  <= (agree & syncC) | (~agree & filt);
    end
  end

  assign csFall   = agree[PIN_CS] & filt[PIN_CS] & ~syncC[PIN_CS];
  assign csRise   = agree[PIN_CS] & ~filt[PIN_CS] & syncC[PIN_CS];
  assign selected = ~filt[PIN_CS];
  assign sckRise  = selected & agree[PIN_SCK]
                  & ~filt[PIN_SCK] & syncC[PIN_SCK];
  assign sckFall  = selected & agree[PIN_SCK]
                  & filt[PIN_SCK] & ~syncC[PIN_SCK];
  assign sioBit   = filt[PIN_SIO];

  ////////////////////////////////////////////////////////////////////////////
  // conversion timing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      convCnt   <= '0;
      result    <= TEMP_RESET;
      firstDone <= 1'b0;
      convPulse <= 1'b0;
    end else if (clkEn) begin
      convPulse <= 1'b0;
      if (!shutdown) begin
        if (convCnt == CONV_CNT_W'(CONV_CYCLES - 1)) begin
          convCnt   <= '0;
          result    <= tempIn;
          firstDone <= 1'b1;
          convPulse <= 1'b1;
        end else begin
          convCnt <= convCnt + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word presented at the start of each read phase
  always_comb begin
    if (shutdown) begin
      wordOut = {IDENT_CODE, IDENT_FILL, UNDEF_BITS};
    end else begin
      wordOut = {result, firstDone, UNDEF_BITS};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link sequencing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase    <= PH_IDLE;
      cnt      <= '0;
      outSr    <= '0;
      inSr     <= '0;
      sioOe    <= 1'b0;
      modeCode <= MODE_RESET;
      shutdown <= 1'b0;
    end else if (clkEn) begin
      if (csFall) begin
        phase <= PH_READ;
        cnt   <= '0;
        outSr <= wordOut;
        sioOe <= 1'b1;
      end else if (csRise) begin
        phase <= PH_IDLE;
        sioOe <= 1'b0;
        // deselect after eight or more write bits keeps last byte
        if (phase == PH_WRITE && cnt >= WRITE_MIN) begin
          modeCode <= inSr[7:0];
          shutdown <= &inSr[7:0];
        end
      end else if (sckFall) begin
        case (phase)
          PH_READ: begin
            if (cnt != READ_LAST) begin
              outSr <= {outSr[WORD_W-2:0], 1'b0};
              cnt   <= cnt + 1'b1;
              sioOe <= (cnt < DRIVE_LAST);
            end
          end
          // next read phase opens on the fall after a write
          PH_ARM: begin
            phase <= PH_READ;
            cnt   <= '0;
            outSr <= wordOut;
            sioOe <= 1'b1;
          end
          default: begin
          end
        endcase
      end else if (sckRise) begin
        case (phase)
          PH_READ: begin
            if (cnt == READ_LAST) begin
              phase <= PH_WRITE;
              cnt   <= '0;
              sioOe <= 1'b0;
            end
          end
          PH_WRITE: begin
            inSr <= {inSr[WORD_W-2:0], sioBit};
            if (cnt == WRITE_LAST) begin
              phase    <= PH_ARM;
              cnt      <= '0;
              modeCode <= {inSr[6:0], sioBit};
              shutdown <= &{inSr[6:0], sioBit};
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data line drive
  assign link.devSioOut = outSr[WORD_W-1];
  assign link.devSioOe  = sioOe;

endmodule

// File: rtl/tsp_host.sv
// host end: APB-programmed controller that runs link transfers
`timescale 1ns/100ps
module tsp_host
  import tsp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  tsp_link_if.host         link,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_LEAD = 5'b00010,
    HS_LOW  = 5'b00100,
    HS_HIGH = 5'b01000,
    HS_TAIL = 5'b10000
  } tsp_hstate_t;

  tsp_hstate_t        state;
  logic [2:0]         sioSync;
  logic               sioF;
  logic               csN;
  logic               sck;
  logic               sioOut;
  logic               sioOe;
  logic [3:0]         halfCnt;
  logic [5:0]         bitsLeft;
  logic [4:0]         rdLeft;
  logic [4:0]         rdLen;
  logic [15:0]        txData;
  logic [15:0]        txSr;
  logic [15:0]        rxSr;
  logic [15:0]        rxData;
  logic               hold;
  logic               busy;
  logic               badCode;
  logic               mapped;
  logic               wrAcc;
  logic               launch;
  logic               doWrite;
  logic               codeOk;
  logic [31:0]        rdMux;

  ////////////////////////////////////////////////////////////////////////////
  // data line synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sioSync <= 3'h7;
      sioF    <= 1'b1;
    end else if (clkEn) begin
      sioSync <= {sioSync[1:0], link.sio};
      if (sioSync[1] == sioSync[2]) begin
        sioF <= sioSync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one access cycle, no waits
  assign mapped  = paddr == OFS_CTRL || paddr == OFS_TXDATA
                || paddr == OFS_STATUS || paddr == OFS_RXDATA;
  assign wrAcc   = psel & penable & pready & pwrite & ~pslverr;
  assign launch  = wrAcc & paddr == OFS_CTRL & pwdata[CTRL_START] & ~busy;
  assign doWrite = pwdata[CTRL_WRITE];
  assign codeOk  = (txData[7:0] & (txData[7:0] + 8'h01)) == 8'h00;
  // a write is only legal after a full 16-bit read
  assign rdLen   = doWrite ? PHASE_BITS
                 : (pwdata[CTRL_RDLEN+4:CTRL_RDLEN] > PHASE_BITS ? PHASE_BITS
                 : pwdata[CTRL_RDLEN+4:CTRL_RDLEN]);

  always_comb begin
    rdMux = '0;
    case (paddr)
      OFS_TXDATA: rdMux[15:0] = txData;
      OFS_STATUS: begin
        rdMux[STAT_BUSY] = busy;
        rdMux[STAT_SEL]  = ~csN;
        rdMux[STAT_BAD]  = badCode;
      end
      OFS_RXDATA: rdMux[15:0] = rxData;
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
      txData  <= '0;
    end else if (clkEn) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable) begin
        prdata <= rdMux;
      end
      if (wrAcc && paddr == OFS_TXDATA) begin
        txData <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= HS_IDLE;
      csN      <= 1'b1;
      sck      <= 1'b0;
      sioOut   <= 1'b0;
      sioOe    <= 1'b0;
      halfCnt  <= '0;
      bitsLeft <= '0;
      rdLeft   <= '0;
      txSr     <= '0;
      rxSr     <= '0;
      rxData   <= '0;
      hold     <= 1'b0;
      busy     <= 1'b0;
      badCode  <= 1'b0;
    end else if (clkEn) begin
      case (state)
        HS_IDLE: begin
          if (launch) begin
            busy     <= 1'b1;
            hold     <= pwdata[CTRL_HOLD];
            rdLeft   <= rdLen;
            bitsLeft <= {1'b0, rdLen} + (doWrite ? 6'h10 : 6'h00);
            txSr     <= {txData[15:8], codeOk ? txData[7:0] : 8'h00};
            badCode  <= doWrite & ~codeOk;
            rxSr     <= '0;
            halfCnt  <= HALF_LAST;
            if (rdLen == 5'h00 && !doWrite) begin
              state <= HS_TAIL;
            end else if (csN) begin
              csN   <= 1'b0;
              state <= HS_LEAD;
            end else begin
              state <= HS_LOW;
            end
          end
        end
        HS_LEAD, HS_LOW: begin
          if (state == HS_LOW && halfCnt == HALF_LAST && rdLeft == 5'h00) begin
            sioOe  <= 1'b1;
            sioOut <= txSr[15];
            txSr   <= {txSr[14:0], 1'b0};
          end
          if (halfCnt == 4'h0) begin
            sck     <= 1'b1;
            halfCnt <= HALF_LAST;
            state   <= HS_HIGH;
            if (rdLeft != 5'h00) begin
              rxSr   <= {rxSr[14:0], sioF};
              rdLeft <= rdLeft - 1'b1;
            end
          end else begin
            halfCnt <= halfCnt - 1'b1;
          end
        end
        HS_HIGH: begin
          if (halfCnt == 4'h0) begin
            sck      <= 1'b0;
            halfCnt  <= HALF_LAST;
            bitsLeft <= bitsLeft - 1'b1;
            state    <= (bitsLeft == 6'h01) ? HS_TAIL : HS_LOW;
          end else begin
            halfCnt <= halfCnt - 1'b1;
          end
        end
        HS_TAIL: begin
          sioOe <= 1'b0;
          if (halfCnt == 4'h0) begin
            csN    <= hold ? csN : 1'b1;
            rxData <= rxSr;
            busy   <= 1'b0;
            state  <= HS_IDLE;
          end else begin
            halfCnt <= halfCnt - 1'b1;
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  assign link.csN        = csN;
  assign link.sck        = sck;
  assign link.hostSioOut = sioOut;
  assign link.hostSioOe  = sioOe;

endmodule

// File: bench/tsp_link_chk.sv
// assertion checker watching the three-wire link
`timescale 1ns/100ps
module tsp_link_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic sck,
  input wire logic hostSioOut,
  input wire logic hostSioOe,
  input wire logic devSioOut,
  input wire logic devSioOe,
  input wire logic sio
);
  logic       sckQ;
  logic [5:0] fallCnt;

  // sck falls seen since select went low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) sckQ <= 1'b0;
    else sckQ <= sck;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) fallCnt <= 6'h00;
    else if (csN) fallCnt <= 6'h00;
    else if (sckQ && !sck) fallCnt <= fallCnt + 6'h01;
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_sck_idle_desel: assert property (csN |-> !sck)
    else $error("sck high while deselected");
  a_dev_quiet: assert property (csN [*8] |-> !devSioOe)
    else $error("sensor drives while deselected");
  a_first_bit: assert property ($fell(csN) |-> ##[2:8] devSioOe)
    else $error("first bit not driven after select");
  a_cs_setup: assert property ($fell(csN) |-> !sck [*3])
    else $error("sck rose too soon after select");
  a_no_fight: assert property (!(hostSioOe && devSioOe))
    else $error("both ends drive data line");
  a_bit_hold: assert property (sck && $past(sck) && devSioOe
    |-> $stable(devSioOut))
    else $error("sensor data moved while sck high");
  a_drive_bits: assert property ($rose(sck) && fallCnt < 6'd14
    |-> devSioOe && sio == devSioOut)
    else $error("sensor bit not driven at rise");
  a_release_tail: assert property ($rose(sck) && fallCnt inside {6'd14, 6'd15}
    |-> !devSioOe)
    else $error("sensor drives low two bits");
  a_host_write: assert property ($rose(sck) && fallCnt >= 6'd16
    && fallCnt < 6'd32 |-> hostSioOe && sio == hostSioOut)
    else $error("host not driving write bit");
  a_sck_high: assert property ($rose(sck) |-> sck [*8])
    else $error("sck high half too short");
endmodule

// File: bench/tb_serial_temp_sensor_port.sv
// testbench: host controller and sensor joined over the link
`timescale 1ns/100ps
module tb_serial_temp_sensor_port import tsp_pkg::*;;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, modeCode;
  logic [31:0] pwdata, prdata, q;
  logic [12:0] tempIn, t;
  logic        shutdown, firstDone, convPulse, shut;
  int          miscompares, checks_done, n;
  logic [7:0]  codes [9] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0f,
                             8'h1f, 8'h3f, 8'h7f, 8'hff};

  tsp_link_if link();
  tsp_sensor #(.CONV_CYCLES(200)) tsp_sensor_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .clkEn(1'b1), .link(link), .tempIn(tempIn),
    .shutdown(shutdown), .modeCode(modeCode), .firstDone(firstDone),
    .convPulse(convPulse));
  tsp_host tsp_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1),
    .link(link), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  tsp_link_chk tsp_link_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .csN(link.csN), .sck(link.sck), .hostSioOut(link.hostSioOut),
    .hostSioOe(link.hostSioOe), .devSioOut(link.devSioOut),
    .devSioOe(link.devSioOe), .sio(link.sio));

  always #25 ref_clk = ~ref_clk;

  //////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask

  // bus cycle: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      check("apb wait", 0, 1);
      results();
    end
    @(posedge ref_clk);
  endtask

  task automatic xfer(input logic [31:0] ctl, input logic [15:0] tx);
    int k;
    k = 0;
    apb(1'b1, OFS_TXDATA, {16'h0000, tx});
    apb(1'b1, OFS_CTRL, ctl);
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      k++;
    end while (q[STAT_BUSY] !== 1'b0 && k < 400);
    if (k >= 400) begin
      check("busy wait", 0, 1);
      results();
    end
    apb(1'b0, OFS_RXDATA, 32'h0);
  endtask

  task automatic waitConv;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (convPulse !== 1'b1 && k < 1000);
    if (k >= 1000) begin
      check("conversion wait", 0, 1);
      results();
    end
  endtask

  // word the host should collect; undriven bits read as pull-up ones
  function automatic logic [15:0] model(input logic s, input logic d,
                                        input logic [12:0] v);
    return s ? {IDENT_CODE, IDENT_FILL, 2'b11} : {v, d, 2'b11};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, tempIn} = '0;
    miscompares = 0;
    checks_done = 0;
    shut = 1'b0;
    n = $urandom(32'h9cc59c45);
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    check("shutdown", shutdown, 0);
    check("modeCode", modeCode, MODE_RESET);
    check("firstDone", firstDone, 0);
    xfer(32'h101, 16'h0);
    check("reset word", q, model(0, 0, TEMP_RESET));
    check("firstDone", firstDone, 1);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped data", q, 0);
    check("unmapped err", err, 1);
    for (int i = 0; i < 4; i++) begin
      t = 13'($urandom);
      n = (i == 0) ? 16 : 1 + $urandom % 15;
      tempIn <= t;
      waitConv();
      waitConv();
      xfer(32'(n << CTRL_RDLEN) | 32'h1, 16'h0);
      check("temp word", q, 32'(model(0, 1, t) >> (16 - n)));
    end
    for (int i = 0; i < 9; i++) begin
      xfer(32'h103, {8'($urandom), codes[i]});
      check("read word", q, model(shut, 1, t));
      shut = (codes[i] == 8'hff);
      check("modeCode", modeCode, codes[i]);
      check("shutdown", shutdown, shut);
    end
    n = 0;
    repeat (600) begin
      @(posedge ref_clk);
      if (convPulse === 1'b1) n++;
    end
    check("conv in shutdown", n, 0);
    xfer(32'h101, 16'h0);
    check("ident", q, model(1, 1, t));
    xfer(32'h103, 16'h0000);
    check("ident again", q, model(1, 1, t));
    check("shutdown", shutdown, 0);
    waitConv();
    xfer(32'h103, 16'h0055);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("bad code", q[STAT_BAD], 1);
    check("modeCode", modeCode, 0);
    apb(1'b0, OFS_TXDATA, 32'h0);
    check("txdata", q, 32'h0055);
    check("status err", err, 0);
    xfer(32'h107, 16'h00ff);
    check("hold temp", q, model(0, 1, t));
    apb(1'b0, OFS_STATUS, 32'h0);
    check("select held", q[STAT_SEL], 1);
    check("shutdown", shutdown, 1);
    xfer(32'h103, 16'h0000);
    check("hold ident", q, model(1, 1, t));
    check("shutdown", shutdown, 0);
    xfer(32'h103, 16'hffff);
    check("shutdown", shutdown, 1);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    check("shutdown", shutdown, 0);
    check("modeCode", modeCode, MODE_RESET);
    check("firstDone", firstDone, 0);
    xfer(32'h101, 16'h0);
    check("reset word", q, model(0, 0, TEMP_RESET));
    results();
  end
endmodule
